// >>> io_status_tabler.sv
`timescale 1ns/1ps
module io_status_tabler
	import io_status_tabler_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
	input  wire logic                    CLK,
	input  wire logic                    RST,
	input  wire logic [NUM_CHANNELS-1:0] CHAN_REQ,
	input  wire logic [NUM_CHANNELS-1:0] STATUS_SERVICE_REQUEST,
	input  wire logic [NUM_CHANNELS-1:0] CHAN_BUF_ERR,
	output logic      [NUM_CHANNELS-1:0] GRANT,
	output logic      [NUM_CHANNELS-1:0] SELECTIVE_RESET,
	output logic                         CPU_HOLD,
	input  wire logic                    CPU_HALTED,
	output logic                         MEM_REQ,
	output logic                         MEM_WE,
	output logic      [23:0]             MEM_ADDR,
	output logic      [31:0]             MEM_WDATA,
	input  wire logic                    MEM_ACK,
	input  wire logic [31:0]             MEM_RDATA,
	input  wire logic                    MEM_ADDR_ERR,
	input  wire logic                    MEM_PAR_ERR,
	input  wire logic                    START_IO_INSTR,
	output logic                         START_IO_DONE,
	output logic      [1:0]              START_IO_CC,
	input  wire logic                    PSW_STATUS_MASK,
	output logic                         STATUS_IRQ,
	input  wire logic                    STATUS_IRQ_ACK,
	input  wire logic                    EXIGENT_ERR,
	input  wire logic                    MACHINE_CHECK_MASK,
	output logic                         MC_REQ,
	output logic                         MC_SYSTEM_DAMAGE,
	output logic                         MC_EXTERNAL_DAMAGE,
	output logic                         MC_CW_EXCEPTION,
	input  wire logic                    MC_ACK,
	output logic                         SUSPENDED
);
	localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

	tab_state_t state_r, state_nxt;
	logic [31:0] ent_r [0:ENTRY_WORDS-1];
	logic [31:0] cw0_r, cw0_nxt, cw1_r, cw1_nxt, cw2_r, cw2_nxt, rd_word;
	logic [1:0]  idx_r, idx_nxt, last_r, last_nxt, sel_r, sel_nxt;
	logic [4:0]  flg_r, flg_nxt;
	logic [TW-1:0] tmr_r, tmr_nxt;
	logic [NUM_CHANNELS-1:0] grant_r, grant_nxt, isr_r, isr_nxt, arb_grant;
	logic [1:0]  arb_idx, cc_r, cc_nxt;
	logic        arb_valid, ent_we;
	logic        err_r, err_nxt, susp_r, susp_nxt, hold_r, hold_nxt;
	logic        irq_pend_r, irq_pend_nxt, irq_out_r, done_r, done_nxt;
	logic        mc_pend_r, mc_pend_nxt, mc_out_r, mc_sd_r, mc_sd_nxt;
	logic        mc_ed_r, mc_ed_nxt, mc_cwe_r, mc_cwe_nxt;
	logic        mem_req_r, mem_req_nxt, mem_we_r, mem_we_nxt;
	logic [23:0] mem_addr_r, mem_addr_nxt, tbl_addr;
	logic [31:0] mem_wdata_r, mem_wdata_nxt, cw2_out;
	logic        ack, bad, busy, is_mem, last_word, acnt_zero;
	logic [13:0] acnt_dec;

	status_priority_arbiter #(.N(NUM_CHANNELS)) u_arb (
		.req   (CHAN_REQ),
		.grant (arb_grant),
		.idx   (arb_idx),
		.valid (arb_valid)
	);

	////////////////////////////////////////////////////////////////////////
	assign ack       = MEM_ACK & mem_req_r;
	assign bad       = MEM_ADDR_ERR | MEM_PAR_ERR;
	assign is_mem    = state_r inside {S_CWRD, S_BRD, S_TCHK, S_TWR, S_CWWR};
	assign busy      = is_mem | (state_r == S_HOLD);
	assign tbl_addr  = cw1_r[23:0];
	assign acnt_dec  = cw0_r[ACNT_HI:ACNT_LO] - 14'h0001;
	assign acnt_zero = (acnt_dec == 14'h0000);
	// fourth word, one-word trace entry, or the word whose continuation bit is clear
	assign last_word = (idx_r == 2'(ENTRY_WORDS - 1)) || !MEM_RDATA[B_CONT]
		|| (idx_r == 2'h0 && MEM_RDATA[B_TRACE]);
	assign cw2_out   = err_r ? {cw2_r[31:16], 6'h00, sel_r, 3'h0, flg_r}
		: cw2_r;
	assign rd_word   = (idx_r == 2'h0) ? cw0_r : (idx_r == 2'h1) ? cw1_r : cw2_out;
	assign ent_we    = (state_r == S_BRD) && ack && !bad;

	assign mem_we_nxt    = (state_r == S_TWR) || (state_r == S_CWWR);
	assign mem_addr_nxt  = (state_r == S_BRD) ? {BUF_BASE[23:4], idx_r, 2'h0}
		: (state_r inside {S_TCHK, S_TWR}) ? tbl_addr
		: {CW_BASE[23:4], idx_r, 2'h0};
	assign mem_wdata_nxt = (state_r == S_TWR) ? ent_r[last_r == 2'h0 ? 2'h0 : idx_r]
		: rd_word;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_nxt = state_r;
		{cw0_nxt, cw1_nxt, cw2_nxt} = {cw0_r, cw1_r, cw2_r};
		{idx_nxt, last_nxt, sel_nxt, flg_nxt} = {idx_r, last_r, sel_r, flg_r};
		{tmr_nxt, grant_nxt, isr_nxt} = {tmr_r, grant_r, 4'h0};
		{err_nxt, susp_nxt, hold_nxt} = {err_r, susp_r, hold_r};
		{cc_nxt, done_nxt} = {cc_r, 1'b0};
		irq_pend_nxt = irq_pend_r & ~STATUS_IRQ_ACK;
		mc_pend_nxt  = mc_pend_r & ~MC_ACK;
		{mc_sd_nxt, mc_ed_nxt, mc_cwe_nxt} = {mc_sd_r, mc_ed_r, mc_cwe_r};
		case (state_r)
		S_IDLE: begin
			if (arb_valid) begin
				grant_nxt = arb_grant;
				sel_nxt   = arb_idx;
				tmr_nxt   = '0;
				{err_nxt, flg_nxt} = {1'b0, 5'h00};
				state_nxt = S_WAIT;
			end
		end
		S_WAIT: begin
			tmr_nxt = tmr_r + TW'(1);
			if (|(STATUS_SERVICE_REQUEST & grant_r)) begin
				state_nxt = S_HOLD;
			end else if (|(CHAN_BUF_ERR & grant_r)) begin
				{err_nxt, flg_nxt[F_CBW], state_nxt} = {2'b11, S_HOLD};
			end else if (tmr_r == TW'(TIMEOUT_CYCLES - 1)) begin
				isr_nxt = grant_r;
				{err_nxt, flg_nxt[F_CTO], state_nxt} = {2'b11, S_HOLD};
			end
			if (state_nxt == S_HOLD) begin
				{grant_nxt, hold_nxt} = {4'h0, 1'b1};
			end
		end
		S_HOLD: begin
			if (CPU_HALTED) begin
				{idx_nxt, state_nxt} = {2'h0, S_CWRD};
			end
		end
		S_CWRD, S_CWWR: begin
			if (ack && bad) begin
				// control word lost: report it, no write-back possible
				{mc_pend_nxt, mc_ed_nxt, mc_cwe_nxt} = 3'b111;
				{err_nxt, irq_pend_nxt} = 2'b11;
				{susp_nxt, hold_nxt, state_nxt} = {2'b10, S_SUSP};
			end else if (ack && state_r == S_CWRD) begin
				idx_nxt = idx_r + 2'h1;
				case (idx_r)
				2'h0: cw0_nxt = MEM_RDATA;
				2'h1: cw1_nxt = MEM_RDATA;
				default: begin
					cw2_nxt = MEM_RDATA;
					idx_nxt = 2'h0;
					state_nxt = S_BRD;
					if (cw1_r[1:0] != 2'h0) begin
						{err_nxt, flg_nxt[F_IWE]} = 2'b11;
					end
					if (err_r || cw1_r[1:0] != 2'h0) begin
						state_nxt = S_CWWR;
					end
				end
				endcase
			end else if (ack) begin
				idx_nxt = idx_r + 2'h1;
				if (idx_r == 2'h2) begin
					{hold_nxt, idx_nxt} = {1'b0, 2'h0};
					// trace entries are logged without an interrupt
					irq_pend_nxt = irq_pend_nxt | err_r
						| !ent_r[0][B_TRACE];
					susp_nxt  = err_r;
					state_nxt = err_r ? S_SUSP : S_IDLE;
				end
			end
		end
		S_BRD, S_TCHK, S_TWR: begin
			if (ack && bad) begin
				{err_nxt, idx_nxt, state_nxt} = {1'b1, 2'h0, S_CWWR};
				flg_nxt[F_IWE] = MEM_ADDR_ERR;
				if (MEM_PAR_ERR && !MEM_ADDR_ERR) begin
					flg_nxt[F_IDE] = 1'b1;
					{mc_pend_nxt, mc_ed_nxt} = 2'b11;
				end
			end else if (ack && state_r == S_BRD) begin
				idx_nxt = idx_r + 2'h1;
				if (last_word) begin
					{last_nxt, idx_nxt, state_nxt} = {idx_r, 2'h0, S_TCHK};
				end
			end else if (ack && state_r == S_TCHK) begin
				// slot still unprocessed by software: table is full
				state_nxt = MEM_RDATA[B_VALID] ? S_TWR : S_CWWR;
				if (!MEM_RDATA[B_VALID]) begin
					{err_nxt, flg_nxt[F_STF], idx_nxt} = {2'b11, 2'h0};
				end
			end else if (ack) begin
				cw0_nxt[ACNT_HI:ACNT_LO] = acnt_zero
					? cw0_r[RCNT_HI:RCNT_LO] : acnt_dec;
				cw1_nxt[15:0] = acnt_zero ? cw2_r[31:16]
					: cw1_r[15:0] + WORD_STEP;
				idx_nxt   = (idx_r == last_r) ? 2'h0 : idx_r + 2'h1;
				state_nxt = (idx_r == last_r) ? S_CWWR : S_TCHK;
			end
		end
		S_SUSP: begin
			grant_nxt = 4'h0;
		end
		default: state_nxt = S_IDLE;
		endcase
		if (EXIGENT_ERR && busy) begin
			{mc_pend_nxt, mc_sd_nxt, mc_ed_nxt} = 3'b111;
			irq_pend_nxt = 1'b0;
			{susp_nxt, hold_nxt, state_nxt} = {2'b10, S_SUSP};
		end
		if (START_IO_INSTR) begin
			done_nxt = 1'b1;
			cc_nxt   = susp_r ? CC_RESUMED : CC_REJECTED;
			if (susp_r) begin
				{susp_nxt, state_nxt} = {1'b0, S_IDLE};
			end
		end
		mem_req_nxt = is_mem && (state_nxt == state_r || !ack) && !MEM_ACK
			&& state_nxt != S_SUSP;
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge CLK) begin
		if (ent_we) begin
			ent_r[idx_r] <= MEM_RDATA;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state_r <= S_IDLE;
			{cw0_r, cw1_r, cw2_r} <= '0;
			{idx_r, last_r, sel_r, flg_r, tmr_r} <= '0;
			{grant_r, isr_r, cc_r, done_r} <= '0;
			{err_r, susp_r, hold_r, irq_pend_r, irq_out_r} <= '0;
			{mc_pend_r, mc_out_r, mc_sd_r, mc_ed_r, mc_cwe_r} <= '0;
			{mem_req_r, mem_we_r, mem_addr_r, mem_wdata_r} <= '0;
		end else begin
			state_r <= state_nxt;
			{cw0_r, cw1_r, cw2_r} <= {cw0_nxt, cw1_nxt, cw2_nxt};
			{idx_r, last_r, sel_r, flg_r} <= {idx_nxt, last_nxt, sel_nxt, flg_nxt};
			{tmr_r, grant_r, isr_r} <= {tmr_nxt, grant_nxt, isr_nxt};
			{cc_r, done_r} <= {cc_nxt, done_nxt};
			{err_r, susp_r, hold_r} <= {err_nxt, susp_nxt, hold_nxt};
			irq_pend_r <= irq_pend_nxt;
			irq_out_r  <= irq_pend_nxt & PSW_STATUS_MASK;
			mc_pend_r  <= mc_pend_nxt;
			mc_out_r   <= mc_pend_nxt & ~MACHINE_CHECK_MASK;
			{mc_sd_r, mc_ed_r, mc_cwe_r} <= {mc_sd_nxt, mc_ed_nxt, mc_cwe_nxt};
			{mem_req_r, mem_we_r} <= {mem_req_nxt, mem_we_nxt};
			{mem_addr_r, mem_wdata_r} <= {mem_addr_nxt, mem_wdata_nxt};
		end
	end

	assign GRANT              = grant_r;
	assign SELECTIVE_RESET    = isr_r;
	assign CPU_HOLD           = hold_r;
	assign MEM_REQ            = mem_req_r;
	assign MEM_WE             = mem_we_r;
	assign MEM_ADDR           = mem_addr_r;
	assign MEM_WDATA          = mem_wdata_r;
	assign START_IO_DONE      = done_r;
	assign START_IO_CC        = cc_r;
	assign STATUS_IRQ         = irq_out_r;
	assign MC_REQ             = mc_out_r;
	assign MC_SYSTEM_DAMAGE   = mc_sd_r;
	assign MC_EXTERNAL_DAMAGE = mc_ed_r;
	assign MC_CW_EXCEPTION    = mc_cwe_r;
	assign SUSPENDED          = susp_r;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	sequence s_sio_when_susp;
		START_IO_INSTR && susp_r;
	endsequence
	sequence s_resumed;
		START_IO_DONE && START_IO_CC == CC_RESUMED && !SUSPENDED;
	endsequence

	property p_one_grant;
		$onehot0(GRANT) && !(GRANT != 4'h0 && CPU_HOLD);
	endproperty
	a_one_grant: assert property (p_one_grant)
		else $error("more than one channel granted");
	property p_prio;
		state_r == S_IDLE && CHAN_REQ[0] && !START_IO_INSTR |=> GRANT == 4'h1;
	endproperty
	a_prio: assert property (p_prio)
		else $error("channel 0 not granted first");
	property p_sio_resume;
		s_sio_when_susp |=> s_resumed ##1 !START_IO_DONE;
	endproperty
	a_sio_resume: assert property (p_sio_resume)
		else $error("start-I/O did not resume");
	property p_sio_reject;
		START_IO_INSTR && !susp_r && state_r != S_SUSP
			|=> START_IO_DONE && START_IO_CC == CC_REJECTED;
	endproperty
	a_sio_reject: assert property (p_sio_reject)
		else $error("start-I/O not rejected");
	property p_susp_no_grant;
		susp_r && !START_IO_INSTR |=> GRANT == 4'h0 && SUSPENDED;
	endproperty
	a_susp_no_grant: assert property (p_susp_no_grant)
		else $error("grant while suspended");
	property p_exigent;
		EXIGENT_ERR && busy && !START_IO_INSTR |=> MC_SYSTEM_DAMAGE
			&& MC_EXTERNAL_DAMAGE && !irq_pend_r && SUSPENDED;
	endproperty
	a_exigent: assert property (p_exigent)
		else $error("exigent check not reported");
	property p_timeout;
		state_r == S_WAIT && tmr_r == TW'(TIMEOUT_CYCLES - 1)
			&& !(|(STATUS_SERVICE_REQUEST & grant_r))
			&& !(|(CHAN_BUF_ERR & grant_r)) |=> SELECTIVE_RESET == $past(GRANT)
			&& flg_r[F_CTO] ##1 SELECTIVE_RESET == 4'h0;
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("timeout did not reset channel");
	property p_count;
		state_r == S_TWR && ack && !bad && !acnt_zero && !EXIGENT_ERR
			|=> cw0_r[ACNT_HI:ACNT_LO] == $past(acnt_dec)
			&& cw1_r[15:0] == $past(cw1_r[15:0]) + WORD_STEP;
	endproperty
	a_count: assert property (p_count)
		else $error("count or address not stepped");
	property p_irq;
		state_r == S_CWWR && ack && !bad && idx_r == 2'h2 && !STATUS_IRQ_ACK
			&& !EXIGENT_ERR && PSW_STATUS_MASK && !ent_r[0][B_TRACE]
			|=> irq_pend_r && STATUS_IRQ;
	endproperty
	a_irq: assert property (p_irq)
		else $error("no status interrupt after tabling");
endmodule

// >>> io_status_tabler_pkg.sv
// Contract
// - trace bit in the first word marks a one-word trace entry
// - start-I/O to the tabler cancels the suspended state
// - start-I/O answers code 00 if it resumed, 11 if rejected
// - buffer or table parity error gives external-damage check and data error
// - exigent check reports system and external damage, drops held interrupt
// - control word access exception gives check with control word flag
// - checks wait for machine check mask low; damage mask cannot stop them
// - a machine check suspends the tabler and refuses channel requests
// - fixed grant priority, channel 0 highest, channel 3 lowest
// - on service request hold the processor, copy entry to table
// - each tabled entry except a trace entry requests an interrupt gated by the status mask
// - pending requests are examined again only after a good store or a resuming start-I/O
// - active count drops by one per word, reloads from replacement
// - active address gains four per word, reloads when count hits zero
// - the granted channel must report in time or is reset and flagged
// - errors record channel address and one flag in the service word
package io_status_tabler_pkg;
	localparam int          NUM_CHANNELS  = 4;
	localparam int          ENTRY_WORDS   = 4;
	localparam logic [23:0] CW_BASE       = 24'h00_0010;
	localparam logic [23:0] BUF_BASE      = 24'h00_00B0;
	localparam logic [15:0] WORD_STEP     = 16'h0004;
	// bit 0 of an entry is the word's least significant bit
	localparam int          B_VALID       = 31;
	localparam int          B_CONT        = 30;
	localparam int          B_TRACE       = 29;
	localparam int          ACNT_HI       = 29;
	localparam int          ACNT_LO       = 16;
	localparam int          RCNT_HI       = 13;
	localparam int          RCNT_LO       = 0;
	localparam int          SW_CH_LO      = 8;
	localparam int          F_IWE         = 4;
	localparam int          F_IDE         = 3;
	localparam int          F_CTO         = 2;
	localparam int          F_CBW         = 1;
	localparam int          F_STF         = 0;
	localparam logic [1:0]  CC_RESUMED    = 2'h0;
	localparam logic [1:0]  CC_REJECTED   = 2'h3;
	localparam int          CLK_HZ        = 20_000_000;
	localparam int          TIMEOUT_US    = 4000;
	localparam int          TIMEOUT_CYC   = TIMEOUT_US * (CLK_HZ / 1_000_000);

	typedef enum logic [8:0] {
		S_IDLE = 9'h001,
		S_WAIT = 9'h002,
		S_HOLD = 9'h004,
		S_CWRD = 9'h008,
		S_BRD  = 9'h010,
		S_TCHK = 9'h020,
		S_TWR  = 9'h040,
		S_CWWR = 9'h080,
		S_SUSP = 9'h100
	} tab_state_t;
endpackage

// >>> status_priority_arbiter.sv
`timescale 1ns/1ps
module status_priority_arbiter
	import io_status_tabler_pkg::*;
#(
	parameter int N = NUM_CHANNELS
) (
	input  wire logic [N-1:0]         req,
	output logic      [N-1:0]         grant,
	output logic      [$clog2(N)-1:0] idx,
	output logic                      valid
);
	// lowest index wins; fixed order keeps channel 0 from ever starving
	function automatic logic [$clog2(N)-1:0] first_set(input logic [N-1:0] v);
		logic [$clog2(N)-1:0] r;
		r = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = ($clog2(N))'(i);
			end
		end
		return r;
	endfunction

	assign valid = |req;
	assign idx   = first_set(req);
	assign grant = valid ? (N'(1) << idx) : '0;
endmodule

// >>> storage_model.sv
`timescale 1ns/1ps
module storage_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        req,
	input  wire logic        we,
	input  wire logic [23:0] addr,
	input  wire logic [31:0] wdata,
	output logic             ack,
	output logic      [31:0] rdata,
	output logic             addr_err,
	output logic             par_err,
	input  wire logic [2:0]  lat,
	input  wire logic [23:0] inj_addr,
	input  wire logic        inj_par,
	input  wire logic        inj_adr
);
	logic [31:0] mem [0:255];
	logic [2:0]  wait_r;
	logic        hit;

	assign hit = addr == inj_addr;

	// table slots start out free so that a full slot is only ever planted
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 32'h8000_0000;
	end

	////////////////////////////////////////////////////////////////////
	// between answers the read bus shows the inverse of its last value,
	// so a read taken off the ack cycle cannot match by luck
	always @(posedge clk) begin
		if (rst) begin
			ack <= 1'b0;
			wait_r <= 3'h0;
			rdata <= 32'h0000_0000;
			addr_err <= 1'b0;
			par_err <= 1'b0;
		end else if (req && !ack && wait_r >= lat) begin
			ack <= 1'b1;
			wait_r <= 3'h0;
			rdata <= mem[addr[9:2]];
			addr_err <= hit && inj_adr;
			par_err <= hit && inj_par;
			if (we) mem[addr[9:2]] <= wdata;
		end else begin
			ack <= 1'b0;
			addr_err <= 1'b0;
			par_err <= 1'b0;
			rdata <= ~rdata;
			wait_r <= (req && !ack) ? wait_r + 3'h1 : 3'h0;
		end
	end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import io_status_tabler_pkg::*;
	localparam logic [31:0] sel0 = 32'h4005_0C00;
	localparam logic [31:0] sel1 = 32'h4000_2000;
	localparam logic [31:0] sel2 = 32'h0000_0010;
	localparam logic [31:0] mux0 = 32'h4317_0000;
	localparam logic [31:0] mux1 = 32'h4400_3000;
	localparam logic [31:0] trc  = 32'h2001_4000;
	logic        CLK, RST, CPU_HALTED, CPU_HOLD, MEM_ACK, MEM_REQ, MEM_WE;
	logic        MEM_ADDR_ERR, MEM_PAR_ERR, START_IO_INSTR, START_IO_DONE;
	logic        PSW_STATUS_MASK, STATUS_IRQ, STATUS_IRQ_ACK, EXIGENT_ERR;
	logic        MACHINE_CHECK_MASK, MC_REQ, MC_SYSTEM_DAMAGE, MC_ACK;
	logic        MC_EXTERNAL_DAMAGE, MC_CW_EXCEPTION, SUSPENDED;
	logic [3:0]  CHAN_REQ, STATUS_SERVICE_REQUEST, CHAN_BUF_ERR, GRANT;
	logic [3:0]  SELECTIVE_RESET;
	logic [23:0] MEM_ADDR, inj_addr;
	logic [31:0] MEM_WDATA, MEM_RDATA;
	logic [1:0]  START_IO_CC;
	logic [2:0]  lat;
	logic        inj_par, inj_adr;
	int          n_mismatch, total_checks;

	io_status_tabler #(.TIMEOUT_CYCLES(20)) DUT (
		.CLK(CLK), .RST(RST), .CHAN_REQ(CHAN_REQ),
		.STATUS_SERVICE_REQUEST(STATUS_SERVICE_REQUEST),
		.CHAN_BUF_ERR(CHAN_BUF_ERR), .GRANT(GRANT),
		.SELECTIVE_RESET(SELECTIVE_RESET), .CPU_HOLD(CPU_HOLD),
		.CPU_HALTED(CPU_HALTED), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
		.MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK),
		.MEM_RDATA(MEM_RDATA), .MEM_ADDR_ERR(MEM_ADDR_ERR),
		.MEM_PAR_ERR(MEM_PAR_ERR), .START_IO_INSTR(START_IO_INSTR),
		.START_IO_DONE(START_IO_DONE), .START_IO_CC(START_IO_CC),
		.PSW_STATUS_MASK(PSW_STATUS_MASK), .STATUS_IRQ(STATUS_IRQ),
		.STATUS_IRQ_ACK(STATUS_IRQ_ACK), .EXIGENT_ERR(EXIGENT_ERR),
		.MACHINE_CHECK_MASK(MACHINE_CHECK_MASK), .MC_REQ(MC_REQ),
		.MC_SYSTEM_DAMAGE(MC_SYSTEM_DAMAGE),
		.MC_EXTERNAL_DAMAGE(MC_EXTERNAL_DAMAGE),
		.MC_CW_EXCEPTION(MC_CW_EXCEPTION), .MC_ACK(MC_ACK),
		.SUSPENDED(SUSPENDED));

	storage_model mem_m (.clk(CLK), .rst(RST), .req(MEM_REQ), .we(MEM_WE),
		.addr(MEM_ADDR), .wdata(MEM_WDATA), .ack(MEM_ACK), .rdata(MEM_RDATA),
		.addr_err(MEM_ADDR_ERR), .par_err(MEM_PAR_ERR), .lat(lat),
		.inj_addr(inj_addr), .inj_par(inj_par), .inj_adr(inj_adr));

	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end

	// the processor stops half a cycle after it is asked to, on the next falling edge
	always @(negedge CLK) CPU_HALTED <= CPU_HOLD;

	////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("mismatches %0d checks %0d", n_mismatch, total_checks);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge CLK);
	endtask

	function automatic logic pick(input int s);
		case (s)
			0: return CPU_HOLD;
			1: return SUSPENDED;
			2: return |GRANT;
			3: return |SELECTIVE_RESET;
			default: return MC_REQ;
		endcase
	endfunction

	task automatic wt(input int s, input logic v);
		int i;
		for (i = 0; i < 500 && pick(s) !== v; i++) @(negedge CLK);
		if (i == 500) begin
			n_mismatch++;
			$display("wrong value at %0t: wait %0d ran out", $time, s);
			close_out();
		end
	endtask

	task automatic pulse_ack(input int s);
		if (s == 0) STATUS_IRQ_ACK = 1'b1;
		else MC_ACK = 1'b1;
		tick(1);
		STATUS_IRQ_ACK = 1'b0;
		MC_ACK = 1'b0;
		tick(1);
	endtask

	task automatic start_io_instr(input logic [1:0] cc);
		START_IO_INSTR = 1'b1;
		tick(1);
		START_IO_INSTR = 1'b0;
		chk(START_IO_DONE, 1, "sio done");
		chk(START_IO_CC, cc, "sio code");
		tick(1);
	endtask

	// a channel: asks, is granted, fills the buffer, then signals service
	task automatic entry(input int ch, input logic [31:0] w0, w1, w2,
		input logic exi);
		CHAN_REQ[ch] = 1'b1;
		wt(2, 1);
		chk(GRANT, 4'h1 << ch, "grant");
		mem_m.mem[44] = w0;
		mem_m.mem[45] = w1;
		mem_m.mem[46] = w2;
		STATUS_SERVICE_REQUEST[ch] = 1'b1;
		CHAN_REQ[ch] = 1'b0;
		tick(1);
		STATUS_SERVICE_REQUEST[ch] = 1'b0;
		wt(0, 1);
		chk(GRANT, 0, "extra grant");
		if (exi) begin
			EXIGENT_ERR = 1'b1;
			tick(1);
			EXIGENT_ERR = 1'b0;
		end
		wt(0, 0);
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		RST = 1'b1;
		{CHAN_REQ, STATUS_SERVICE_REQUEST, CHAN_BUF_ERR} = '0;
		{START_IO_INSTR, PSW_STATUS_MASK, STATUS_IRQ_ACK, EXIGENT_ERR} = '0;
		{MC_ACK, inj_par, inj_adr} = '0;
		MACHINE_CHECK_MASK = 1'b1;
		inj_addr = 24'h00_0000;
		lat = 3'h0;
		n_mismatch = 0;
		total_checks = 0;
		tick(2);
		RST = 1'b0;
		start_io_instr(CC_REJECTED);
		mem_m.mem[4] = 32'h0002_0009;
		mem_m.mem[5] = 32'h0000_0200;
		mem_m.mem[6] = 32'h0300_0000;
		CHAN_REQ[3] = 1'b1;
		entry(0, sel0, sel1, sel2, 0);
		chk(mem_m.mem[128], sel0, "slot a");
		chk(mem_m.mem[129], sel1, "slot b");
		chk(mem_m.mem[192], sel2, "reload slot");
		chk(mem_m.mem[4], 32'h0008_0009, "count");
		chk(mem_m.mem[5][15:0], 16'h0304, "address");
		chk(STATUS_IRQ, 0, "masked irq");
		lat = 3'h3;
		entry(3, mux0, mux1, 32'h0000_0000, 0);
		chk(mem_m.mem[194], mux1, "mux word");
		chk(mem_m.mem[195], 0, "mux last");
		chk(mem_m.mem[4], 32'h0005_0009, "count");
		PSW_STATUS_MASK = 1'b1;
		tick(2);
		chk(STATUS_IRQ, 1, "irq");
		pulse_ack(0);
		chk(STATUS_IRQ, 0, "irq cleared");
		entry(1, trc, sel1, sel2, 0);
		chk(mem_m.mem[196], trc, "trace");
		chk(mem_m.mem[197], 32'h8000_0000, "trace len");
		chk(STATUS_IRQ, 0, "trace irq");
		mem_m.mem[197] = 32'h0000_0000;
		entry(2, sel0, sel1, sel2, 0);
		chk(SUSPENDED, 1, "full");
		chk(mem_m.mem[6], 32'h0300_0201, "full word");
		mem_m.mem[197] = 32'h8000_0000;
		start_io_instr(CC_RESUMED);
		chk(SUSPENDED, 0, "resume");
		inj_addr = 24'h00_00B0;
		inj_par = 1'b1;
		entry(1, sel0, sel1, sel2, 0);
		inj_par = 1'b0;
		chk(MC_EXTERNAL_DAMAGE, 1, "damage");
		chk(mem_m.mem[6], 32'h0300_0108, "data err");
		CHAN_REQ[1] = 1'b1;
		tick(4);
		chk(GRANT, 0, "suspended grant");
		chk(MC_REQ, 0, "mc masked");
		MACHINE_CHECK_MASK = 1'b0;
		wt(4, 1);
		pulse_ack(1);
		start_io_instr(CC_RESUMED);
		wt(2, 1);
		wt(3, 1);
		chk(SELECTIVE_RESET, 4'h2, "reset pulse");
		CHAN_REQ[1] = 1'b0;
		wt(0, 1);
		wt(0, 0);
		chk(SUSPENDED, 1, "timeout");
		chk(mem_m.mem[6], 32'h0300_0104, "timeout word");
		start_io_instr(CC_RESUMED);
		CHAN_REQ[2] = 1'b1;
		wt(2, 1);
		CHAN_BUF_ERR[2] = 1'b1;
		CHAN_REQ[2] = 1'b0;
		tick(1);
		CHAN_BUF_ERR[2] = 1'b0;
		wt(0, 1);
		wt(0, 0);
		chk(SUSPENDED, 1, "buffer error");
		chk(mem_m.mem[6], 32'h0300_0202, "buffer word");
		start_io_instr(CC_RESUMED);
		pulse_ack(0);
		chk(STATUS_IRQ, 0, "irq idle");
		inj_addr = 24'h00_0010;
		inj_adr = 1'b1;
		entry(0, sel0, sel1, sel2, 0);
		inj_adr = 1'b0;
		chk(MC_CW_EXCEPTION, 1, "cw flag");
		chk(SUSPENDED, 1, "cw suspend");
		wt(4, 1);
		chk(STATUS_IRQ, 1, "cw irq");
		pulse_ack(1);
		start_io_instr(CC_RESUMED);
		entry(0, sel0, sel1, sel2, 1);
		chk(STATUS_IRQ, 0, "held irq");
		chk(MC_SYSTEM_DAMAGE, 1, "sys damage");
		chk(SUSPENDED, 1, "exigent");
		close_out();
	end
endmodule
